// [rtl/scs_pkg.sv]
// Package of register map, field layout and reset values for clock select
package scs_pkg;
  // Register byte offsets
  localparam logic [7:0] SCS_SYSCFG_OFF = 8'h00;
  localparam logic [7:0] SCS_PLLCFG_OFF = 8'h04;
  localparam logic [7:0] SCS_STATUS_OFF = 8'h08;
  // system_clock_config fields
  localparam int SCS_SRC_LSB = 0;
  localparam int SCS_REFSEL_BIT = 4;
  // pll_config fields, then the K1 config field
  localparam int SCS_PLL_INPUT_DIVIDER_LSB = 0;
  localparam int SCS_PLL_INPUT_DIVIDER_W = 4;
  localparam int SCS_PLL_FEEDBACK_MULTIPLIER_LSB = 8;
  localparam int SCS_PLL_FEEDBACK_MULTIPLIER_W = 7;
  localparam int SCS_K2_LSB = 16;
  localparam int SCS_K2_W = 7;
  localparam int SCS_BAND_LSB = 24;
  localparam int SCS_BYP_BIT = 26;
  localparam int SCS_K1_LSB = 0;
  localparam int SCS_K1_W = 10;
  // Reset values, then the K1 config register offset
  localparam logic [1:0] SCS_SRC_RST = 2'h0;
  localparam logic [31:0] SCS_PLLCFG_RST = 32'h0400_0000;
  localparam logic [9:0] SCS_K1_RST = 10'h000;
  localparam logic [7:0] SCS_K1CFG_OFF = 8'h0c;
  typedef enum logic [1:0] {
    SCS_SRC_WAKEUP = 2'h0,
    SCS_SRC_RSVD = 2'h1,
    SCS_SRC_PLL = 2'h2,
    SCS_SRC_DIRECT = 2'h3
  } scs_src_t;
  typedef enum logic [1:0] {
    SCS_BAND_LOW = 2'h0,
    SCS_BAND_HIGH = 2'h1
  } scs_band_t;
endpackage : scs_pkg

// [rtl/scs_div.sv]
// Enable-pulse divider: one pulse every div_m1+1 input enables
`timescale 1ns/1ps
module scs_div #(
  parameter int W = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic en_in,
  input wire logic [W-1:0] div_m1,
  output logic en_out
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
    end else if (en_in) begin
      if (cnt_q >= div_m1) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign en_out = en_in && (cnt_q >= div_m1);
endmodule : scs_div

// [rtl/scs_clock_select.sv]
// System clock source select with PLL rate model behind an AHB-Lite slave
// Contract
// - Source 10, no bypass: PLL drives clock
// - PLL rate is input times N/(P*K2)
// - Each divider equals its field plus one
// - PLL reference: crystal or on-chip oscillator
// - System clock is VCO divided by K2
// - Band 00 low, 01 high; 1X reserved
// - Source 00: wakeup clock passed directly
// - Source 11: direct input passed directly
// - Bypass: oscillator divided by K1, max 1024
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module scs_clock_select
#(
  parameter int PW = scs_pkg::SCS_PLL_INPUT_DIVIDER_W,
  parameter int NW = scs_pkg::SCS_PLL_FEEDBACK_MULTIPLIER_W,
  parameter int KW = scs_pkg::SCS_K2_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic crystal_en,
  input wire logic onchip_osc_en,
  input wire logic wakeup_en,
  input wire logic direct_clock_input_en,
  output logic sys_clk_en,
  output logic [1:0] active_source
);
  import scs_pkg::*;

  logic [1:0] src_q;
  logic ref_sel_q;
  logic [31:0] pll_cfg_q;
  logic [9:0] k1_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [1:0] act_src_q;
  logic act_pll_q;
  logic pend_q;
  logic osc_en;
  logic vco_en;
  logic pfd_en;
  logic pll_out_en;
  logic presc_en;
  logic path_en;
  logic new_en;
  logic [1:0] want_src;
  logic want_pll;
  logic [31:0] rd_d;

  // Address phase capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // Configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_q <= SCS_SRC_RST;
      ref_sel_q <= 1'b0;
      pll_cfg_q <= SCS_PLLCFG_RST;
      k1_q <= SCS_K1_RST;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        SCS_SYSCFG_OFF: begin
          src_q <= hwdata[SCS_SRC_LSB +: 2];
          ref_sel_q <= hwdata[SCS_REFSEL_BIT];
        end
        SCS_PLLCFG_OFF: begin
          pll_cfg_q <= hwdata;
          // Reserved band codes are kept out of the hardware
          if (hwdata[SCS_BAND_LSB + 1]) begin
            pll_cfg_q[SCS_BAND_LSB +: 2] <= pll_cfg_q[SCS_BAND_LSB +: 2];
          end
        end
        SCS_K1CFG_OFF: k1_q <= hwdata[SCS_K1_LSB +: SCS_K1_W];
        default: ;
      endcase
    end
  end

  // Reads are answered with zero wait states
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (haddr[7:0])
      SCS_SYSCFG_OFF: begin
        rd_d[SCS_SRC_LSB +: 2] = src_q;
        rd_d[SCS_REFSEL_BIT] = ref_sel_q;
      end
      SCS_PLLCFG_OFF: rd_d = pll_cfg_q & 32'h077f_7f0f;
      SCS_STATUS_OFF: begin
        rd_d[1:0] = act_src_q;
        rd_d[2] = act_pll_q;
        rd_d[3] = pend_q;
      end
      SCS_K1CFG_OFF: rd_d[SCS_K1_LSB +: SCS_K1_W] = k1_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Reference choice
  assign osc_en = ref_sel_q ? onchip_osc_en : crystal_en;

  // Input divider P, then VCO rate from feedback N
  scs_div #(.W(PW)) u_pll_input_divider (
    .clk(clk),
    .sys_rst(sys_rst),
    .en_in(osc_en),
    .div_m1(pll_cfg_q[SCS_PLL_INPUT_DIVIDER_LSB +: PW]),
    .en_out(pfd_en)
  );
  logic [NW:0] vco_cnt_q;
  // Rate model: VCO ticks N times per reference tick, spread one per clk
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vco_cnt_q <= '0;
    end else if (pfd_en) begin
      vco_cnt_q <= {1'b0, pll_cfg_q[SCS_PLL_FEEDBACK_MULTIPLIER_LSB +: NW]} + 1'b1;
    end else if (vco_cnt_q != '0) begin
      vco_cnt_q <= vco_cnt_q - 1'b1;
    end
  end
  assign vco_en = (vco_cnt_q != '0);

  scs_div #(.W(KW)) u_pll_output_divider (
    .clk(clk),
    .sys_rst(sys_rst),
    .en_in(vco_en),
    .div_m1(pll_cfg_q[SCS_K2_LSB +: KW]),
    .en_out(pll_out_en)
  );

  scs_div #(.W(SCS_K1_W)) u_prescaler_divider (
    .clk(clk),
    .sys_rst(sys_rst),
    .en_in(osc_en),
    .div_m1(k1_q),
    .en_out(presc_en)
  );

  always_comb begin
    want_src = src_q;
    want_pll = !pll_cfg_q[SCS_BYP_BIT];
  end

  // Switch only at a tick of both the old and the new source so no short period appears
  always_comb begin
    unique case (want_src)
      SCS_SRC_WAKEUP: new_en = wakeup_en;
      SCS_SRC_PLL: new_en = want_pll ? pll_out_en : presc_en;
      SCS_SRC_DIRECT: new_en = direct_clock_input_en;
      default: new_en = wakeup_en;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      act_src_q <= SCS_SRC_RST;
      // Follow the reset bypass so no switch is pending
      act_pll_q <= !SCS_PLLCFG_RST[SCS_BYP_BIT];
      pend_q <= 1'b0;
    end else if ((want_src != act_src_q) || (want_pll != act_pll_q)) begin
      pend_q <= 1'b1;
      if (path_en && new_en) begin
        act_src_q <= want_src;
        act_pll_q <= want_pll;
        pend_q <= 1'b0;
      end
    end else begin
      pend_q <= 1'b0;
    end
  end

  always_comb begin
    unique case (act_src_q)
      SCS_SRC_WAKEUP: path_en = wakeup_en;
      SCS_SRC_PLL: path_en = act_pll_q ? pll_out_en : presc_en;
      SCS_SRC_DIRECT: path_en = direct_clock_input_en;
      default: path_en = wakeup_en;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= path_en;
    end
  end

  assign active_source = act_src_q;
endmodule : scs_clock_select

// [dv/scs_osc_model.sv]
// Far-side pulse model of crystal, oscillator and clock inputs
`timescale 1ns/1ps
module scs_osc_model (
  input wire logic clk,
  output logic crystal_en = 1'b0,
  output logic onchip_osc_en = 1'b0,
  output logic wakeup_en = 1'b0,
  output logic direct_clock_input_en = 1'b0
);
  int n = 0;
  // One shared count so that sources meet, else a switch waits forever
  always @(posedge clk) begin
    n <= n + 1;
    crystal_en <= n % 20 == 0;
    onchip_osc_en <= n % 24 == 0;
    // Gaps keep the wakeup path visible at the output
    wakeup_en <= n % 7 != 0;
    direct_clock_input_en <= n % 4 == 0;
  end
endmodule : scs_osc_model

// [dv/scs_clock_select_asserts.sv]
// Port checker for the clock source select block
`timescale 1ns/1ps
module scs_clock_select_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic wakeup_en,
  input wire logic direct_clock_input_en,
  input wire logic sys_clk_en,
  input wire logic [1:0] active_source
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rd_a(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence
  sequence held(logic [1:0] s);
    active_source == s && $past(active_source) == s && !$past(sys_rst);
  endsequence
  a_wake_pass: assert property (held(2'h0) |->
    sys_clk_en == $past(wakeup_en)) else $error("wakeup pass");
  a_direct_pass: assert property (held(2'h3) |->
    sys_clk_en == $past(direct_clock_input_en)) else $error("direct");
  a_switch_aligned: assert property ($changed(active_source) &&
    !$past(sys_rst) |-> sys_clk_en) else $error("switch off pulse");
  a_rst_quiet: assert property (disable iff (1'b0) sys_rst |=>
    !sys_clk_en && active_source == 2'h0 && hrdata == 32'h0)
    else $error("reset state");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response");
  a_stat_read: assert property (rd_a(8'h08) |=>
    hrdata[1:0] == $past(active_source)) else $error("status read");
  a_unmap_zero: assert property (rd_a(8'h10) |=> hrdata == 32'h0)
    else $error("unmapped read");
  a_rdata_hold: assert property (!(hsel && hready && htrans[1] &&
    !hwrite) |=> $stable(hrdata)) else $error("read data moved");
endmodule : scs_clock_select_asserts

bind scs_clock_select scs_clock_select_asserts u_scs_clock_select_asserts (
  .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp, .wakeup_en, .direct_clock_input_en, .sys_clk_en,
  .active_source);

// [dv/scs_clock_select_tb_top.sv]
// Testbench for the system clock source select
`timescale 1ns/1ps
module scs_clock_select_tb_top;
  import scs_pkg::*;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, rd_dp = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, c;
  logic [1:0] htrans = 0, active_source;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, sys_clk_en, crystal_en, onchip_osc_en;
  logic wakeup_en, direct_clock_input_en;
  logic [31:0] q[$];
  int fails = 0, checks_done = 0, k, n, m, j;
  scs_clock_select u_scs_clock_select (.clk, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .crystal_en, .onchip_osc_en, .wakeup_en,
    .direct_clock_input_en, .sys_clk_en, .active_source);
  scs_osc_model u_scs_osc_model (.clk, .crystal_en, .onchip_osc_en,
    .wakeup_en, .direct_clock_input_en);
  initial forever #5 clk = ~clk;
  task automatic cmp(logic [31:0] got, logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, e);
    end
  endtask : cmp
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    if (!w) q.push_back(d);
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus
  always @(posedge clk) if (rd_dp) cmp(hrdata, q.pop_front());
  task automatic go(logic [31:0] cfg, logic [1:0] s);
    bus(1, 8'h00, cfg);
    k = 0;
    while (active_source !== s && k < 3000) begin
      @(posedge clk);
      k++;
    end
    cmp(active_source, s);
  endtask : go
  // Settle first: a fresh path needs a few ticks to reach steady rate
  task automatic rate(int win, int e);
    n = 0;
    repeat (100) @(posedge clk);
    repeat (win) @(posedge clk) n += (sys_clk_en === 1'b1);
    cmp(n, e);
    $display("rate test done at %0t", $time);
  endtask : rate
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    fails++;
    print_verdict;
  end
  initial begin
    void'($urandom(94210));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, 8'h04, SCS_PLLCFG_RST);
    bus(0, 8'h10, 32'h0);
    rate(700, 600);
    go(32'h3, 2'h3);
    rate(600, 150);
    bus(0, 8'h08, 32'h3);
    for (j = 0; j < 2; j++) begin
      go(32'h0, 2'h0);
      m = $urandom_range(3);
      bus(1, 8'h0c, m);
      go(32'h2 | (j << 4), 2'h2);
      rate((j ? 24 : 20) * (m + 1) * 20, 20);
    end
    for (j = 0; j < 2; j++) begin
      go(32'h0, 2'h0);
      m = $urandom_range(7);
      k = $urandom_range(1);
      c = (j << 24) | (k << 16) | (m << 8);
      bus(1, 8'h04, c);
      bus(1, 8'h04, c | 32'h0200_0000);
      bus(0, 8'h04, c);
      n = k;
      go(32'h2, 2'h2);
      rate(20 * (n + 1) * 20, (m + 1) * 20);
      bus(0, 8'h08, 32'h6);
    end
    print_verdict;
  end
endmodule : scs_clock_select_tb_top
